// ==== core/ptps_pkg.sv ====
// Package of constants and types for the pattern table PWM sequencer
// Contract
// - Pattern bytes move from ROM to six output bits without processor help.
// - Each output bit drives exactly one power switch, no decoding.
// - Six bits form three leg pairs, high and low side, phases u v w.
// - The two spare port bits stay free for other uses.
// - Dead time lives in the pattern data; both switches of a leg never on.
// - All bytes of one pattern in order form one switching cycle.
// - A pattern replays to fill one sine step, then the next pattern replays.
// - Controller is signalled only at a pattern's last byte, then picks next.
// - One timer paces transfers; one output port carries all six signals.
// - Bit one means switch on, zero means off.
// - Low side is opposite its high side except in dead time units.
// - Each leg change has a one time unit dead interval, both edges.
package ptps_pkg;
  localparam logic [7:0] PTPS_OFF_CTRL = 8'h00;
  localparam logic [7:0] PTPS_OFF_PAT = 8'h04;
  localparam logic [7:0] PTPS_OFF_STAT = 8'h08;
  localparam logic [7:0] PTPS_OFF_IRQ = 8'h0C;
  localparam logic [7:0] PTPS_OFF_MASK = 8'h10;
  localparam logic [7:0] PTPS_OFF_SPARE = 8'h14;
  localparam logic [7:0] PTPS_OFF_TIMER = 8'h18;
  localparam logic [7:0] PTPS_OFF_ROMWR = 8'h1C;
  // Time unit 4.75 us at 4 ns clock
  localparam int PTPS_CLK_PS = 4000;
  localparam int PTPS_UNIT_PS = 4750000;
  localparam logic [15:0] PTPS_UNIT_CYC = 16'(PTPS_UNIT_PS / PTPS_CLK_PS);
  localparam int PTPS_ROM_AW = 13;
  localparam logic [7:0] PTPS_PAT_LEN_RST = 8'h2A;
  localparam logic [15:0] PTPS_REPEAT_RST = 16'h0001;
  localparam logic [5:0] PTPS_SW_OFF = 6'h00;
  typedef enum logic [1:0] {PTPS_ST_IDLE, PTPS_ST_RUN, PTPS_ST_WAIT} ptps_state_t;
  typedef struct packed {
    logic [1:0] w;
    logic [1:0] v;
    logic [1:0] u;
  } ptps_legs_t;
  typedef struct packed {
    logic [PTPS_ROM_AW-1:0] base;
    logic [7:0] len;
    logic [15:0] repeat_n;
  } ptps_pat_t;
endpackage

// ==== core/ptps_seq.sv ====
// Pattern table PWM sequencer with AHB-Lite registers and pattern ROM
module ptps_seq
  import ptps_pkg::*;
#(
  parameter int ROM_AW = PTPS_ROM_AW
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output ptps_legs_t legs,
  output logic [1:0] spare,
  output logic irq
);
  // Pattern memory is written by software, then treated as read-only
  logic [7:0] rom [0:(1<<ROM_AW)-1];
  logic [ROM_AW-1:0] rom_fill;
  logic [7:0] rom_q;

  logic wr_pend;
  logic rd_pend;
  logic [7:0] addr_q;
  logic enable;
  logic [1:0] spare_reg;
  logic [15:0] period;
  ptps_pat_t cur;
  ptps_pat_t nxt;
  logic nxt_valid;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  ptps_state_t state;
  logic [7:0] byte_idx;
  logic [15:0] rep_cnt;
  logic tick;
  logic last_byte;
  logic last_rep;
  logic underrun_ev;
  logic load_ev;
  logic end_ev;
  logic [ROM_AW-1:0] rd_addr;

  function automatic logic leg_ok(input logic [1:0] pair);
    leg_ok = !(pair[0] && pair[1]);
  endfunction

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend <= hsel && htrans[1] && hwrite;
      rd_pend <= hsel && htrans[1] && !hwrite;
      addr_q <= haddr[7:0];
    end
  end

  // Control and queued pattern registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      enable <= 1'b0;
      spare_reg <= 2'b00;
      period <= PTPS_UNIT_CYC;
      irq_mask <= 2'b00;
      rom_fill <= '0;
      nxt <= '{base: '0, len: PTPS_PAT_LEN_RST, repeat_n: PTPS_REPEAT_RST};
      nxt_valid <= 1'b0;
    end
    else
    begin
      // Queue is consumed once; a write in the same cycle queues anew
      if (end_ev || load_ev)
        nxt_valid <= 1'b0;
      if (wr_pend)
      begin
        case (addr_q)
          PTPS_OFF_CTRL: enable <= hwdata[0];
          PTPS_OFF_PAT:
          begin
            // Controller picks repeat or new pattern
            nxt.base <= hwdata[ROM_AW-1:0];
            nxt.len <= hwdata[23:16];
            nxt_valid <= 1'b1;
          end
          PTPS_OFF_MASK: irq_mask <= hwdata[1:0];
          PTPS_OFF_SPARE: spare_reg <= hwdata[1:0];
          PTPS_OFF_TIMER:
          begin
            period <= hwdata[15:0];
            nxt.repeat_n <= hwdata[31:16];
          end
          PTPS_OFF_ROMWR:
          begin
            rom_fill <= hwdata[8+ROM_AW-1:8];
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge hclk)
  begin
    if (wr_pend && addr_q == PTPS_OFF_ROMWR)
      rom[hwdata[8+ROM_AW-1:8]] <= hwdata[7:0];
    rom_q <= rom[rd_addr];
  end

  // Read data
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (hready && hsel && htrans[1] && !hwrite)
    begin
      case (haddr[7:0])
        PTPS_OFF_CTRL: hrdata <= {31'h00000000, enable};
        PTPS_OFF_PAT: hrdata <= {8'h00, nxt.len, 16'(nxt.base)};
        PTPS_OFF_STAT: hrdata <= {byte_idx, rep_cnt[7:0], 13'h0000, nxt_valid,
          2'(state)};
        PTPS_OFF_IRQ: hrdata <= {30'h00000000, irq_stat};
        PTPS_OFF_MASK: hrdata <= {30'h00000000, irq_mask};
        PTPS_OFF_SPARE: hrdata <= {30'h00000000, spare_reg};
        PTPS_OFF_TIMER: hrdata <= {nxt.repeat_n, period};
        PTPS_OFF_ROMWR: hrdata <= {16'h0000, 8'(rom_fill), 8'h00};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  ptps_timer u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(enable && state != PTPS_ST_IDLE),
    .period(period),
    .tick(tick)
  );

  assign last_byte = (byte_idx + 8'h01 >= cur.len);
  assign last_rep = (rep_cnt + 16'h0001 >= cur.repeat_n);
  assign end_ev = enable && tick && state == PTPS_ST_RUN && last_byte && last_rep
    && nxt_valid;
  assign underrun_ev = enable && tick && state == PTPS_ST_RUN && last_byte && last_rep
    && !nxt_valid;
  assign load_ev = enable && nxt_valid && (state == PTPS_ST_IDLE || state == PTPS_ST_WAIT);
  assign rd_addr = ROM_AW'(cur.base + ROM_AW'(byte_idx));

  // Byte transfer engine, no processor involvement
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= PTPS_ST_IDLE;
      byte_idx <= 8'h00;
      rep_cnt <= 16'h0000;
      cur <= '{base: '0, len: PTPS_PAT_LEN_RST, repeat_n: PTPS_REPEAT_RST};
    end
    else if (!enable)
      state <= PTPS_ST_IDLE;
    else
    begin
      case (state)
        PTPS_ST_IDLE:
          if (nxt_valid)
          begin
            cur <= nxt;
            byte_idx <= 8'h00;
            rep_cnt <= 16'h0000;
            state <= PTPS_ST_RUN;
          end
        PTPS_ST_RUN:
          if (tick)
          begin
            if (!last_byte)
              byte_idx <= byte_idx + 8'h01;
            else if (!last_rep)
            begin
              byte_idx <= 8'h00;
              rep_cnt <= rep_cnt + 16'h0001;
            end
            else if (nxt_valid)
            begin
              cur <= nxt;
              byte_idx <= 8'h00;
              rep_cnt <= 16'h0000;
            end
            else
              state <= PTPS_ST_WAIT;
          end
        PTPS_ST_WAIT:
          // Hold last byte rather than glitch; resume when next queued
          if (nxt_valid)
          begin
            cur <= nxt;
            byte_idx <= 8'h00;
            rep_cnt <= 16'h0000;
            state <= PTPS_ST_RUN;
          end
        default: state <= PTPS_ST_IDLE;
      endcase
    end
  end

  // Output port: one register, all bits on one edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      legs <= PTPS_SW_OFF;
    else if (!enable)
      legs <= PTPS_SW_OFF;
    else if (state == PTPS_ST_RUN && tick)
    begin
      // Bit order u_hi u_lo v_hi v_lo w_hi w_lo, one means on
      // Dead time comes from the data; a shoot-through pair is blocked anyway
      legs.u <= leg_ok(rom_q[1:0]) ? rom_q[1:0] : 2'b00;
      legs.v <= leg_ok(rom_q[3:2]) ? rom_q[3:2] : 2'b00;
      legs.w <= leg_ok(rom_q[5:4]) ? rom_q[5:4] : 2'b00;
    end
  end

  assign spare = spare_reg;

  // Sticky events: bit0 pattern end, bit1 underrun; set beats clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_stat <= 2'b00;
    else
    begin
      irq_stat[0] <= end_ev || (irq_stat[0] &&
        !(wr_pend && addr_q == PTPS_OFF_IRQ && hwdata[0]));
      irq_stat[1] <= underrun_ev || (irq_stat[1] &&
        !(wr_pend && addr_q == PTPS_OFF_IRQ && hwdata[1]));
    end
  end

  assign irq = |(irq_stat & irq_mask);

  property p_no_shoot;
    @(posedge hclk) disable iff (!hresetn)
    leg_ok(legs.u) && leg_ok(legs.v) && leg_ok(legs.w);
  endproperty
  a_no_shoot: assert property (p_no_shoot) else $error("Leg shoot-through");

  property p_off_idle;
    @(posedge hclk) disable iff (!hresetn)
    (!enable) |=> (legs == PTPS_SW_OFF);
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("Switches on while disabled");

  property p_hold;
    @(posedge hclk) disable iff (!hresetn)
    (!tick && enable) |=> $stable(legs);
  endproperty
  a_hold: assert property (p_hold) else $error("Output changed off tick");

  property p_end_irq;
    @(posedge hclk) disable iff (!hresetn)
    end_ev |=> irq_stat[0];
  endproperty
  a_end_irq: assert property (p_end_irq) else $error("End event lost");

  property p_end_last;
    @(posedge hclk) disable iff (!hresetn)
    end_ev |=> (byte_idx == 8'h00 && rep_cnt == 16'h0000 && state == PTPS_ST_RUN);
  endproperty
  a_end_last: assert property (p_end_last) else $error("Next pattern not from start");

  property p_wrap;
    @(posedge hclk) disable iff (!hresetn)
    (tick && state == PTPS_ST_RUN && last_byte && !last_rep && enable)
      |=> (byte_idx == 8'h00 && rep_cnt == $past(rep_cnt) + 16'h0001);
  endproperty
  a_wrap: assert property (p_wrap) else $error("Repeat not counted");

  property p_step;
    @(posedge hclk) disable iff (!hresetn)
    (tick && state == PTPS_ST_RUN && !last_byte && enable)
      |=> (byte_idx == $past(byte_idx) + 8'h01);
  endproperty
  a_step: assert property (p_step) else $error("Byte index not advanced");

  property p_irq;
    @(posedge hclk) disable iff (!hresetn)
    underrun_ev |=> (irq_stat[1] && state == PTPS_ST_WAIT);
  endproperty
  a_irq: assert property (p_irq) else $error("Underrun not flagged");

  c_end: cover property (@(posedge hclk) disable iff (!hresetn) end_ev);
  c_under: cover property (@(posedge hclk) disable iff (!hresetn) underrun_ev);
  c_rep: cover property (@(posedge hclk) disable iff (!hresetn)
    tick && last_byte && !last_rep);
endmodule

// ==== core/ptps_timer.sv ====
// Time unit divider producing one enable pulse per time unit
module ptps_timer
  import ptps_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic [15:0] period,
  output logic tick
);
  logic [15:0] count;

  // Single pacing timer for all transfers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count <= 16'h0000;
      tick <= 1'b0;
    end
    else if (!run)
    begin
      count <= 16'h0000;
      tick <= 1'b0;
    end
    else if (count + 16'h0001 >= period)
    begin
      count <= 16'h0000;
      tick <= 1'b1;
    end
    else
    begin
      count <= count + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule

// ==== sim/ptps_gate_model.sv ====
// Behavioural gate drivers of the six bridge switches
module ptps_gate_model
  import ptps_pkg::*;
(
  input wire logic hclk,
  input wire ptps_legs_t legs,
  output logic [5:0] gate_on,
  output int n_shoot
);
  timeunit 1ns;
  timeprecision 1ps;
  initial gate_on = 6'h00;
  initial n_shoot = 0;
  // Count cross conduction instead of blowing up, so the bench can report it
  always @(posedge hclk)
  begin
    gate_on <= legs;
    if (legs.u == 2'b11 || legs.v == 2'b11 || legs.w == 2'b11)
      n_shoot <= n_shoot + 1;
  end
endmodule

// ==== sim/ptps_seq_tb_top.sv ====
// Testbench for the pattern table PWM sequencer
module ptps_seq_tb_top;
  import ptps_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, mon, irq_mid;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, spare;
  logic [2:0] hsize;
  ptps_legs_t legs, last;
  logic [5:0] gate_on;
  int n_shoot, n_mismatch, checks, cyc, lastc;
  logic [5:0] seq[$];
  int gaps[$];
  logic [7:0] rom_b[6] = '{8'h09, 8'h0F, 8'hC6, 8'h24, 8'h12, 8'h21};
  logic [5:0] exp_seq[10] = '{6'h09, 6'h00, 6'h06, 6'h24, 6'h09, 6'h00, 6'h06, 6'h24,
    6'h12, 6'h21};
  assign hready = hreadyout;
  always #2 hclk = ~hclk;
  ptps_seq ptps_seq_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .legs(legs), .spare(spare),
    .irq(irq));
  ptps_gate_model ptps_gate_model_inst (.hclk(hclk), .legs(legs), .gate_on(gate_on),
    .n_shoot(n_shoot));
  // Record every change of the switch word and its spacing in clocks
  always @(posedge hclk)
  begin
    cyc++;
    if (mon && legs !== last)
    begin
      seq.push_back(legs);
      gaps.push_back(cyc - lastc);
      lastc = cyc;
      last = legs;
      if (seq.size() == 6)
        irq_mid = irq;
    end
  end
  task automatic wrap_up;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Bounded wait for hready at a rising edge
  task automatic rdy;
    int i;
    i = 0;
    do
    begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (i >= 50)
    begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    rdy();
    rd = hrdata;
  endtask
  task automatic settle;
    repeat (2) @(posedge hclk);
  endtask
  initial
  begin
    hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'b010;
    hwdata = 0; mon = 0; irq_mid = 1'bx; last = 6'h00; cyc = 0; lastc = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(0, PTPS_OFF_TIMER, 0);
    chk("timer_rst", rd, 32'h0001_04A3);
    ahb(0, 8'h40, 0);
    chk("unmapped", rd, 32'h0000_0000);
    for (int i = 0; i < 6; i++)
      ahb(1, PTPS_OFF_ROMWR, {11'h000, 13'(i), rom_b[i]});
    ahb(1, PTPS_OFF_TIMER, 32'h0002_0008);
    ahb(1, PTPS_OFF_PAT, 32'h0004_0000);
    ahb(1, PTPS_OFF_MASK, 32'h0000_0003);
    chk("legs_idle", {26'h0, legs}, 0);
    mon = 1;
    ahb(1, PTPS_OFF_CTRL, 32'h0000_0001);
    ahb(1, PTPS_OFF_TIMER, 32'h0001_0008);
    ahb(1, PTPS_OFF_PAT, 32'h0002_0004);
    for (int i = 0; i < 200 && rd[1:0] !== 2'b10; i++)
      ahb(0, PTPS_OFF_STAT, 0);
    chk("stat_wait", rd, 32'h0100_0002);
    chk("seq_len", seq.size(), 10);
    for (int i = 0; i < 10 && i < seq.size(); i++)
      chk("legs_seq", {26'h0, seq[i]}, {26'h0, exp_seq[i]});
    for (int i = 1; i < gaps.size(); i++)
      chk("tick_gap", gaps[i], 8);
    chk("no_shoot", n_shoot, 0);
    chk("irq_mid", irq_mid, 0);
    chk("irq_end", irq, 1);
    ahb(0, PTPS_OFF_IRQ, 0);
    chk("irq_stat", rd, 32'h0000_0003);
    ahb(1, PTPS_OFF_MASK, 0);
    settle();
    chk("irq_masked", irq, 0);
    ahb(1, PTPS_OFF_MASK, 32'h0000_0003);
    ahb(1, PTPS_OFF_IRQ, 32'h0000_0001);
    settle();
    chk("irq_hold", irq, 1);
    ahb(0, PTPS_OFF_IRQ, 0);
    chk("irq_w1c", rd, 32'h0000_0002);
    ahb(1, PTPS_OFF_IRQ, 32'h0000_0002);
    settle();
    chk("irq_clr", irq, 0);
    ahb(1, PTPS_OFF_SPARE, 32'hFFFF_FFFE);
    settle();
    chk("spare", spare, 2'b10);
    chk("legs_kept", {26'h0, legs}, 32'h0000_0021);
    chk("gate_kept", {26'h0, gate_on}, 32'h0000_0021);
    chk("hresp", {31'h0, hresp}, 0);
    ahb(1, PTPS_OFF_CTRL, 0);
    settle();
    chk("legs_off", {26'h0, legs}, 0);
    wrap_up();
  end
  initial
  begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    wrap_up();
  end
endmodule
